// ---- core/keypad_pkg.sv ----
/*
  Package for the keypad key level logic: register map, field layouts,
  reset values and delay timing.
  Assumes a 32-bit APB register bus and a 10 MHz clock.
*/
package keypad_pkg;
  localparam int NUM_KEYS    = 20;
  localparam int NUM_EXPORTS = 8;
  localparam int NUM_LEVELS  = 8;
  localparam int DELAY_W     = 16;
  localparam int CLK_MHZ     = 10;
  localparam int MS_NS       = 1000000;
  localparam int CLK_NS      = 100;
  localparam int MS_CYCLES   = MS_NS / CLK_NS;
  localparam int KEY_STRIDE  = 32'h0000_0010;
  localparam int EXP_STRIDE  = 32'h0000_0020;

  localparam logic [11:0] CTRL_OFF    = 12'h000;
  localparam logic [11:0] STAT_OFF    = 12'h004;
  localparam logic [11:0] TXBITS_OFF  = 12'h008;
  localparam logic [11:0] LEGRX_OFF   = 12'h00C;
  localparam logic [11:0] KEY_BASE    = 12'h100;
  localparam logic [11:0] EXP_BASE    = 12'h400;

  localparam logic [2:0] INIT_LEVEL_RST = 3'h0;
  localparam logic [2:0] MAX_LEVEL_RST  = 3'h1;

  typedef enum logic [1:0] {SRC_LOCAL, SRC_ONE, SRC_TWO} light_src_t;

  typedef struct packed {
    logic [4:0]    group;
    logic          allow_none;
    logic [1:0]    red_src;
    logic [1:0]    green_src;
    logic          advanced;
    logic          momentary;
    logic [2:0]    max_level;
    logic [2:0]    init_level;
  } key_cfg_t;

  typedef struct packed {
    logic [DELAY_W-1:0] release_ms;
    logic [DELAY_W-1:0] press_ms;
  } key_delay_t;

  typedef struct packed {
    logic        valid;
    logic        is_word;
    logic [15:0] data;
  } export_out_t;
endpackage

// ---- core/key_delay.sv ----
/*
  Per-key press and release debounce delay in milliseconds.
  Assumes a synchronous key level and a common millisecond tick.
*/
`timescale 1ns/10ps
`default_nettype none
module key_delay #(
  parameter int DW = 16
) (
  // Clock and reset
  input  wire logic          pclk,
  input  wire logic          presetn,
  // Settings
  input  wire logic          ms_tick,
  input  wire logic [DW-1:0] press_ms,
  input  wire logic [DW-1:0] release_ms,
  // Key
  input  wire logic          raw,
  output logic               held
);
  logic [DW-1:0] cnt_reg;
  logic [DW-1:0] cnt_next;
  logic          held_reg;
  logic          held_next;
  logic [DW-1:0] limit;

  always_comb begin
    limit     = raw ? press_ms : release_ms;
    cnt_next  = cnt_reg;
    held_next = held_reg;
    if (raw == held_reg) begin
      cnt_next = '0;
    end else if (limit == '0 || (ms_tick && cnt_reg + 1'b1 >= limit)) begin
      held_next = raw; // R8
      cnt_next  = '0;
    end else if (ms_tick) begin
      cnt_next = cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg  <= '0;
      held_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      held_reg <= held_next;
    end
  end

  assign held = held_reg;
endmodule
`default_nettype wire

// ---- core/keypad_levels.sv ----
/*
  Keypad key level logic: latching and momentary action, levels, groups,
  indicator lights, legacy transmit bits and secondary export values.
  Assumes synchronous key inputs, CAN status decoded outside, APB master.
*/
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// R1 - Latching key toggles status on each press.
// R2 - Momentary key is on only while held.
// R3 - Eight levels at most; maximum level caps status.
// R4 - Standard mode status is 0 or 1.
// R5 - Advanced mode status is 0 or 1 to 7.
// R6 - Status loads initial level before any press.
// R7 - Each key holds a configurable maximum level.
// R8 - Press and release delays; zero means immediate.
// R9 - Local green light follows the key press.
// R10 - Legacy green light follows remote output on.
// R11 - CAN errors light every red light.
// R12 - Local red off; legacy red follows remote fault.
// R13 - Eight export packages, byte or word, each with identifier.
// R14 - Export maps current level to configured value.
// R15 - Values above 255 force word export.
// R16 - Export value zero marks level unused.
// R17 - Each key is its own group by default; one group each.
// R18 - Activating a key clears others in its group.
// R19 - Pressing active key again clears it when allowed.
// R20 - Without no-selection, active key stays until another pressed.
// R21 - Legacy transmit bits: keys to bytes 7, 6, 5.
// R22 - Advanced latching press steps level, wraps after maximum.
module keypad_levels #(
  parameter int NK = keypad_pkg::NUM_KEYS,
  parameter int NE = keypad_pkg::NUM_EXPORTS
) (
  // APB
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Keys and remote status
  input  wire logic [NK-1:0] key_in,
  input  wire logic [NK-1:0] remote_on_one,
  input  wire logic [NK-1:0] remote_on_two,
  input  wire logic [NK-1:0] remote_fault_one,
  input  wire logic [NK-1:0] remote_fault_two,
  input  wire logic          can_error,
  // Lights and transmit data
  output logic [NK-1:0]    green_led,
  output logic [NK-1:0]    red_led,
  output logic [63:0]      legacy_tx,
  output keypad_pkg::export_out_t [NE-1:0] export_out
);
  keypad_pkg::key_cfg_t    [NK-1:0] cfg_reg;
  keypad_pkg::key_cfg_t    [NK-1:0] cfg_next;
  keypad_pkg::key_delay_t  [NK-1:0] dly_reg;
  keypad_pkg::key_delay_t  [NK-1:0] dly_next;
  logic [NE-1:0][7:0][15:0]         val_reg;
  logic [NE-1:0][7:0][15:0]         val_next;
  logic [NE-1:0][4:0]               src_reg;
  logic [NE-1:0][4:0]               src_next;
  logic [NE-1:0][28:0]              ident_reg;
  logic [NE-1:0][28:0]              ident_next;
  logic [NK-1:0][2:0]               lvl_reg;
  logic [NK-1:0][2:0]               lvl_next;
  logic [NK-1:0]                    prev_reg;
  logic [NK-1:0]                    prev_next;
  logic                             loaded_reg;
  logic                             loaded_next;
  logic                             restart;
  logic [31:0]                      prdata_reg;
  logic [31:0]                      prdata_next;
  logic                             pready_reg;
  logic                             pready_next;
  logic                             err_reg;
  logic                             err_next;
  logic [NK-1:0]                    green_reg;
  logic [NK-1:0]                    green_next;
  logic [NK-1:0]                    red_reg;
  logic [NK-1:0]                    red_next;
  logic [63:0]                      tx_reg;
  logic [63:0]                      tx_next;
  keypad_pkg::export_out_t [NE-1:0] exp_reg;
  keypad_pkg::export_out_t [NE-1:0] exp_next;
  logic [NK-1:0]                    held;
  logic [15:0]                      ms_cnt_reg;
  logic [15:0]                      ms_cnt_next;
  logic                             ms_tick;

  // Millisecond tick for the delay counters
  always_comb begin
    ms_tick     = (ms_cnt_reg == 16'(keypad_pkg::MS_CYCLES - 1));
    ms_cnt_next = ms_tick ? 16'h0000 : ms_cnt_reg + 16'h0001;
  end

  // Millisecond counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ms_cnt_reg <= 16'h0000;
    end else begin
      ms_cnt_reg <= ms_cnt_next;
    end
  end

  for (genvar k = 0; k < NK; k++) begin : g_dly
    key_delay #(.DW(keypad_pkg::DELAY_W)) u_dly (
      .pclk       (pclk),
      .presetn    (presetn),
      .ms_tick    (ms_tick),
      .press_ms   (dly_reg[k].press_ms),
      .release_ms (dly_reg[k].release_ms),
      .raw        (key_in[k]),
      .held       (held[k])
    );
  end

  // APB register access, answered one cycle into the access phase
  logic        wr;
  logic        rd;
  logic [11:0] koff;
  logic [11:0] eoff;
  int          ki;
  int          ei;
  int          vi;
  assign wr = psel && penable && pwrite && !pready_reg;
  assign rd = psel && penable && !pwrite && !pready_reg;
  assign koff = paddr - keypad_pkg::KEY_BASE;
  assign eoff = paddr - keypad_pkg::EXP_BASE;
  // Writing bit 0 of the control word reloads every initial level
  assign restart = wr && paddr == keypad_pkg::CTRL_OFF && pwdata[0]; // R6

  always_comb begin
    cfg_next    = cfg_reg;
    dly_next    = dly_reg;
    val_next    = val_reg;
    src_next    = src_reg;
    ident_next  = ident_reg;
    prdata_next = prdata_reg;
    err_next    = 1'b0;
    pready_next = psel && penable && !pready_reg;
    ki = int'(koff[11:4]);
    ei = int'(eoff[11:5]);
    vi = int'(eoff[4:2]);
    if (psel && penable && !pready_reg) begin
      prdata_next = 32'h0000_0000;
      if (paddr == keypad_pkg::STAT_OFF) begin
        if (rd) prdata_next = {8'h00, green_reg[7:0], red_reg[7:0], 8'h00};
      end else if (paddr == keypad_pkg::TXBITS_OFF) begin
        if (rd) prdata_next = tx_reg[63:32];
      end else if (paddr >= keypad_pkg::KEY_BASE && ki < NK) begin
        unique case (koff[3:2])
          2'd0: begin
            if (wr) cfg_next[ki] = pwdata[17:0];
            if (rd) prdata_next = {14'h0000, cfg_reg[ki]};
          end
          2'd1: begin
            if (wr) dly_next[ki] = pwdata;
            if (rd) prdata_next = dly_reg[ki];
          end
          2'd2: if (rd) prdata_next = {29'h0000_0000, lvl_reg[ki]};
          default: err_next = 1'b1;
        endcase
      end else if (paddr >= keypad_pkg::EXP_BASE && ei < NE) begin
        if (eoff[4:0] == 5'h00) begin
          if (wr) src_next[ei] = pwdata[4:0];
          if (wr) ident_next[ei] = 29'(pwdata[31:5]);
          if (rd) prdata_next = {ident_reg[ei][26:0], src_reg[ei]};
        end else begin
          if (wr) val_next[ei][vi] = pwdata[15:0]; // R13
          if (rd) prdata_next = {16'h0000, val_reg[ei][vi]};
        end
      end else if (paddr != keypad_pkg::CTRL_OFF) begin
        err_next = 1'b1;
      end
    end
  end

  // Key status levels and groups
  logic [2:0] top;
  logic       press;
  logic       take;
  always_comb begin
    lvl_next    = lvl_reg;
    prev_next   = held;
    loaded_next = !restart; // R6
    top = 3'h0;
    press = 1'b0;
    take = 1'b0;
    for (int k = 0; k < NK; k++) begin
      top = cfg_reg[k].advanced ? cfg_reg[k].max_level : 3'h1; // R3 R4 R5 R7
      if (top == 3'h0) top = 3'h1;
      press = held[k] && !prev_reg[k];
      if (!loaded_reg) begin
        lvl_next[k] = (cfg_reg[k].init_level > top) ? top
                    : cfg_reg[k].init_level; // R6
      end else if (cfg_reg[k].momentary) begin
        lvl_next[k] = held[k] ? top : 3'h0; // R2
      end else if (press) begin
        if (lvl_reg[k] >= top) begin
          if (cfg_reg[k].allow_none || cfg_reg[k].advanced)
            lvl_next[k] = 3'h0; // R1 R19 R22
        end else begin
          lvl_next[k] = lvl_reg[k] + 3'h1; // R1 R22
        end
        if (!cfg_reg[k].allow_none && lvl_reg[k] != 3'h0
            && !cfg_reg[k].advanced) lvl_next[k] = lvl_reg[k]; // R20
      end
    end
    // Any key that turns on, except by an initial level load, clears its group mates
    for (int k = 0; k < NK; k++) begin
      take = loaded_reg && lvl_next[k] != 3'h0 && lvl_reg[k] == 3'h0;
      for (int j = 0; j < NK; j++) begin
        if (take && j != k && cfg_reg[j].group == cfg_reg[k].group)
          lvl_next[j] = 3'h0; // R17 R18
      end
    end
  end

  // Lights from key, remote status and CAN error
  always_comb begin
    for (int k = 0; k < NK; k++) begin
      unique case (cfg_reg[k].green_src)
        keypad_pkg::SRC_ONE: green_next[k] = remote_on_one[k]; // R10
        keypad_pkg::SRC_TWO: green_next[k] = remote_on_two[k]; // R10
        default:             green_next[k] = held[k]; // R9
      endcase
      unique case (cfg_reg[k].red_src)
        keypad_pkg::SRC_ONE: red_next[k] = remote_fault_one[k]; // R12
        keypad_pkg::SRC_TWO: red_next[k] = remote_fault_two[k]; // R12
        default:             red_next[k] = 1'b0; // R12
      endcase
      if (can_error) red_next[k] = 1'b1; // R11
    end
  end

  // Legacy transmit bits
  always_comb begin
    tx_next = 64'h0000_0000_0000_0000;
    for (int k = 0; k < NK && k < 20; k++) begin
      tx_next[56 - 8 * (k / 8) + (k % 8)] = (lvl_reg[k] != 3'h0); // R21
    end
  end

  // Secondary exports
  always_comb begin
    for (int e = 0; e < NE; e++) begin
      exp_next[e].data  = 16'h0000;
      exp_next[e].valid = 1'b0;
      exp_next[e].is_word = 1'b0;
      for (int v = 0; v < keypad_pkg::NUM_LEVELS; v++) begin
        if (val_reg[e][v] > 16'h00FF) exp_next[e].is_word = 1'b1; // R15
      end
      if (int'(src_reg[e]) < NK) begin
        exp_next[e].data = val_reg[e][lvl_reg[src_reg[e]]]; // R14
        exp_next[e].valid = (exp_next[e].data != 16'h0000); // R16
      end
    end
  end

  // Register file and bus answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int k = 0; k < NK; k++) begin
        cfg_reg[k].group      <= 5'(k); // R17
        cfg_reg[k].allow_none <= 1'b1;
        cfg_reg[k].red_src    <= 2'h0;
        cfg_reg[k].green_src  <= 2'h0;
        cfg_reg[k].advanced   <= 1'b0;
        cfg_reg[k].momentary  <= 1'b0;
        cfg_reg[k].max_level  <= keypad_pkg::MAX_LEVEL_RST;
        cfg_reg[k].init_level <= keypad_pkg::INIT_LEVEL_RST;
      end
      dly_reg    <= '0;
      val_reg    <= '0;
      src_reg    <= '0;
      ident_reg  <= '0;
      prdata_reg <= 32'h0000_0000;
      pready_reg <= 1'b0;
      err_reg    <= 1'b0;
    end else begin
      cfg_reg    <= cfg_next;
      dly_reg    <= dly_next;
      val_reg    <= val_next;
      src_reg    <= src_next;
      ident_reg  <= ident_next;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      err_reg    <= err_next;
    end
  end

  // Key levels
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lvl_reg    <= '0;
      prev_reg   <= '0;
      loaded_reg <= 1'b0;
    end else begin
      lvl_reg    <= lvl_next;
      prev_reg   <= prev_next;
      loaded_reg <= loaded_next;
    end
  end

  // Lights
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      green_reg <= '0;
      red_reg   <= '0;
    end else begin
      green_reg <= green_next;
      red_reg   <= red_next;
    end
  end

  // Legacy transmit word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_reg <= 64'h0000_0000_0000_0000;
    end else begin
      tx_reg <= tx_next;
    end
  end

  // Export words
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      exp_reg <= '0;
    end else begin
      exp_reg <= exp_next;
    end
  end

  assign prdata     = prdata_reg;
  assign pready     = pready_reg;
  assign pslverr    = err_reg;
  assign green_led  = green_reg;
  assign red_led    = red_reg;
  assign legacy_tx  = tx_reg;
  assign export_out = exp_reg;
endmodule
`default_nettype wire

// ---- verification/keypad_levels_chk.sv ----
/* Checker for keypad_levels: bus timing, lights, exports, transmit bits.
   Assumes one clock, bound to the design's top module. */
`timescale 1ns/10ps
`default_nettype none
module keypad_levels_chk #(
  parameter int NK = 20,
  parameter int NE = 8
) (
  // Bus
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // Keys, remote and lights
  input wire logic [NK-1:0] key_in,
  input wire logic [NK-1:0] remote_on_one,
  input wire logic [NK-1:0] remote_on_two,
  input wire logic [NK-1:0] remote_fault_one,
  input wire logic [NK-1:0] remote_fault_two,
  input wire logic          can_error,
  input wire logic [NK-1:0] green_led,
  input wire logic [NK-1:0] red_led,
  input wire logic [63:0]   legacy_tx,
  input wire keypad_pkg::export_out_t [NE-1:0] export_out
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic bad_v;
  logic bad_w;
  always_comb begin
    bad_v = 1'b0;
    bad_w = 1'b0;
    for (int e = 0; e < NE; e++) begin
      if (export_out[e].valid != (export_out[e].data != '0)) bad_v = 1'b1;
      if (export_out[e].data > 255 && !export_out[e].is_word) bad_w = 1'b1;
    end
  end
  sequence s_acc;
    psel && $rose(penable);
  endsequence
  sequence s_no_fault;
    (!can_error && remote_fault_one == '0 && remote_fault_two == '0) [*4];
  endsequence
  sequence s_no_on;
    (key_in == '0 && remote_on_one == '0 && remote_on_two == '0) [*4];
  endsequence
  chk_ready_wait: assert property (s_acc |=> pready)
    else $error("ready late");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("ready too long");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  chk_can_red: assert property (can_error [*4] |-> red_led == '1)
    else $error("red not forced");
  chk_red_quiet: assert property (s_no_fault |-> red_led == '0)
    else $error("red without cause");
  chk_green_quiet: assert property (s_no_on |-> green_led == '0)
    else $error("green without cause");
  chk_exp_valid: assert property (!bad_v)
    else $error("export valid wrong");
  chk_exp_word: assert property (!bad_w)
    else $error("export width wrong");
  chk_tx_unused: assert property (legacy_tx[39:0] == '0 &&
    legacy_tx[47:44] == '0) else $error("stray transmit bit");
endmodule
bind keypad_levels keypad_levels_chk #(.NK(NK), .NE(NE)) i_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .key_in(key_in),
  .remote_on_one(remote_on_one), .remote_on_two(remote_on_two),
  .remote_fault_one(remote_fault_one), .remote_fault_two(remote_fault_two),
  .can_error(can_error), .green_led(green_led), .red_led(red_led),
  .legacy_tx(legacy_tx), .export_out(export_out));
`default_nettype wire

// ---- verification/pdm_model.sv ----
/* Power distribution model: reports outputs on or in fault per key.
   Assumes legacy transmit bits from the keypad and the same clock. */
`timescale 1ns/10ps
`default_nettype none
module pdm_model (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Commands and bench controls
  input  wire logic [63:0] legacy_tx,
  input  wire logic [19:0] fault_mask,
  input  wire logic        bus_fail,
  // Reported status
  output logic      [19:0] on_one,
  output logic      [19:0] on_two,
  output logic      [19:0] fault_one,
  output logic      [19:0] fault_two,
  output logic             can_error
);
  logic [19:0] cmd;
  assign cmd = {legacy_tx[43:40], legacy_tx[55:48], legacy_tx[63:56]};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      on_one <= '0;
      on_two <= '0;
      fault_one <= '0;
      fault_two <= '0;
      can_error <= 1'b0;
    end else begin
      on_one <= cmd & ~fault_mask;
      on_two <= cmd & ~fault_mask;
      fault_one <= cmd & fault_mask;
      fault_two <= cmd & fault_mask;
      can_error <= bus_fail;
    end
  end
endmodule
`default_nettype wire

// ---- verification/test_keypad_levels.sv ----
/* Testbench for keypad_levels with a power distribution model.
   Assumes the package constants and the design's millisecond tick. */
`timescale 1ns/10ps
`default_nettype none
module test_keypad_levels;
  logic                 pclk, presetn, psel, penable, pwrite, pready;
  logic                 pslverr, perr, bus_fail, can_error;
  logic [11:0]          paddr;
  logic [31:0]          pwdata, prdata, rd;
  logic [19:0]          key_in, on1, on2, f1, f2, green_led, red_led, fmask;
  logic [63:0]          legacy_tx;
  keypad_pkg::key_cfg_t c;
  int                   failures, cmp_count;
  keypad_pkg::export_out_t [7:0] export_out;
  keypad_levels i_keypad_levels (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .key_in(key_in), .remote_on_one(on1), .remote_on_two(on2),
    .remote_fault_one(f1), .remote_fault_two(f2), .can_error(can_error),
    .green_led(green_led), .red_led(red_led), .legacy_tx(legacy_tx),
    .export_out(export_out));
  pdm_model i_pdm_model (.pclk(pclk), .presetn(presetn),
    .legacy_tx(legacy_tx), .fault_mask(fmask), .bus_fail(bus_fail),
    .on_one(on1), .on_two(on2), .fault_one(f1), .fault_two(f2),
    .can_error(can_error));
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  task automatic chk(input string nm, input logic [31:0] e, g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  function automatic logic [11:0] kb(input int k);
    return keypad_pkg::KEY_BASE + 12'(k * keypad_pkg::KEY_STRIDE);
  endfunction
  function automatic keypad_pkg::key_cfg_t mk(int g, logic an, mo, ad, int mx);
    keypad_pkg::key_cfg_t r;
    r = '0;
    r.group = 5'(g);
    r.allow_none = an;
    r.momentary = mo;
    r.advanced = ad;
    r.max_level = 3'(mx);
    return r;
  endfunction
  task automatic setk(input int k, input keypad_pkg::key_cfg_t v);
    apb(1'b1, kb(k), 32'(v));
    apb(1'b1, kb(k) + 12'h004, 32'h0000_0000);
  endtask
  task automatic lvl(input int k, input int e);
    apb(1'b0, kb(k) + 12'h008, 32'h0000_0000);
    chk("level", 32'(e), rd);
  endtask
  task automatic hold(input int k, input logic v);
    key_in[k] <= v;
    repeat (6) @(posedge pclk);
  endtask
  task automatic press(input int k);
    hold(k, 1'b1);
    hold(k, 1'b0);
  endtask
  task automatic wrap_up;
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic t_reset;
    lvl(0, 0);
    c = mk(3, 1'b1, 1'b0, 1'b0, keypad_pkg::MAX_LEVEL_RST);
    c.init_level = keypad_pkg::INIT_LEVEL_RST;
    apb(1'b0, kb(3), 32'h0000_0000);
    chk("cfg3", 32'(c), rd);
    apb(1'b0, 12'h3F0, 32'h0000_0000);
    chk("slverr", 32'h0000_0001, 32'(perr));
    c = mk(8, 1'b1, 1'b0, 1'b0, 1);
    c.init_level = 3'h1;
    setk(8, c);
    apb(1'b1, keypad_pkg::CTRL_OFF, 32'h0000_0001);
    lvl(8, 1);
    $display("reset test done");
  endtask
  task automatic t_delay;
    apb(1'b1, kb(9) + 12'h004, 32'h0000_0001);
    hold(9, 1'b1);
    lvl(9, 0);
    repeat (keypad_pkg::MS_CYCLES) @(posedge pclk);
    lvl(9, 1);
    hold(9, 1'b0);
    $display("delay test done");
  endtask
  task automatic t_export;
    setk(10, mk(10, 1'b1, 1'b0, 1'b1, 2));
    apb(1'b1, keypad_pkg::EXP_BASE, 32'h0000_012A);
    apb(1'b1, keypad_pkg::EXP_BASE + 12'h004, 32'h0000_1234);
    apb(1'b1, keypad_pkg::EXP_BASE + 12'h008, 32'h0000_0055);
    apb(1'b1, keypad_pkg::EXP_BASE + 12'h020, 32'h0000_000A);
    apb(1'b1, keypad_pkg::EXP_BASE + 12'h024, 32'h0000_00FF);
    apb(1'b0, keypad_pkg::EXP_BASE, 32'h0000_0000);
    chk("exp_id", 32'h0000_012A, rd);
    chk("exp0", 32'h0001_0000, 32'(export_out[0]));
    press(10);
    chk("exp0", 32'h0003_1234, 32'(export_out[0]));
    chk("exp1", 32'h0002_00FF, 32'(export_out[1]));
    press(10);
    chk("exp0", 32'h0003_0055, 32'(export_out[0]));
    chk("exp1", 32'h0000_0000, 32'(export_out[1]));
    $display("export test done");
  endtask
  task automatic t_keys;
    setk(17, mk(17, 1'b1, 1'b0, 1'b0, 1));
    hold(17, 1'b1);
    chk("green17", 32'h0000_0001, 32'(green_led[17]));
    hold(17, 1'b0);
    lvl(17, 1);
    chk("tx41", 32'h0000_0001, 32'(legacy_tx[41]));
    press(17);
    lvl(17, 0);
    setk(1, mk(1, 1'b1, 1'b1, 1'b0, 1));
    hold(1, 1'b1);
    lvl(1, 1);
    hold(1, 1'b0);
    lvl(1, 0);
    setk(2, mk(2, 1'b1, 1'b0, 1'b1, 3));
    for (int i = 1; i <= 4; i++) begin
      press(2);
      lvl(2, i % 4);
    end
    $display("key test done");
  endtask
  task automatic t_group;
    setk(4, mk(4, 1'b0, 1'b0, 1'b0, 1));
    setk(5, mk(4, 1'b0, 1'b0, 1'b0, 1));
    press(4);
    press(4);
    lvl(4, 1);
    press(5);
    lvl(5, 1);
    lvl(4, 0);
    $display("group test done");
  endtask
  task automatic t_lights;
    c = mk(6, 1'b1, 1'b0, 1'b0, 1);
    c.green_src = keypad_pkg::SRC_ONE;
    c.red_src = keypad_pkg::SRC_TWO;
    setk(6, c);
    press(6);
    chk("green6", 32'h0000_0001, 32'(green_led[6]));
    fmask[6] <= 1'b1;
    repeat (6) @(posedge pclk);
    chk("red6", 32'h0000_0001, 32'(red_led[6]));
    chk("green6", 32'h0000_0000, 32'(green_led[6]));
    bus_fail <= 1'b1;
    repeat (6) @(posedge pclk);
    chk("red", 32'h000F_FFFF, 32'(red_led));
    bus_fail <= 1'b0;
    $display("light test done");
  endtask
  initial begin
    {psel, penable, pwrite, bus_fail, presetn} = '0;
    {paddr, pwdata, key_in, fmask} = '0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_delay();
    t_keys();
    t_group();
    t_lights();
    t_export();
    wrap_up();
  end
  initial begin
    repeat (30000) @(posedge pclk);
    failures++;
    wrap_up();
  end
endmodule
`default_nettype wire
